// ===== memory_ecc_parity_checker.sv
// memory check path: parity or ecc generation, checking, correction, gather and rmw
`default_nettype none
`include "ecc_map.svh"

module memory_ecc_parity_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // configuration
  input wire ecc_pkg::mode_t cfg_mode_i,
  input wire logic cfg_err_mcp_i,
  // requests from processor and pci
  input wire logic req_valid_i,
  input wire ecc_pkg::req_t req_i,
  output logic req_ready_o,
  // processor read answer
  output logic [`DATA_W-1:0] cpu_data_o,
  output logic transfer_ack_n_o,
  output logic transfer_error_ack_n_o,
  output logic machine_check_n_o,
  output logic data_retry_n_o,
  // pci read answer
  output logic [`DATA_W-1:0] pci_data_o,
  output logic pci_data_valid_o,
  output logic pci_serr_n_o,
  // dram sequencer
  output ecc_pkg::mem_req_t mem_req_o,
  input wire logic [`DATA_W-1:0] mem_rdata_i,
  input wire logic [`CHK_W-1:0] mem_rchk_i,
  input wire logic mem_rvalid_i
);

  typedef enum logic [2:0] {S_IDLE, S_RD_WAIT, S_RD_CHECK, S_RMW_RD} state_t;

  state_t state_q;
  state_t state_d;
  ecc_pkg::mode_t mode_q;
  ecc_pkg::req_t cur_q;
  ecc_pkg::mem_req_t mem_q;
  logic ready_q;
  logic [`DATA_W-1:0] raw_q;
  logic [`CHK_W-1:0] raw_chk_q;
  logic [`DATA_W-1:0] wd_q;
  logic [`CHK_W-1:0] wbe_q;
  logic [`HALF_W-1:0] hold_q;
  logic [3:0] hold_be_q;
  logic [`GRP_W-1:0] hold_grp_q;
  logic hold_vld_q;
  logic [`DATA_W-1:0] cpu_data_q;
  logic ta_n_q;
  logic tea_n_q;
  logic mcp_n_q;
  logic [`DATA_W-1:0] pci_data_q;
  logic pci_vld_q;
  logic serr_n_q;

  logic acc;
  logic ecc;
  logic gather;
  logic combine;
  logic need_rmw;
  logic [`DATA_W-1:0] wdata;
  logic [`CHK_W-1:0] wbe;
  logic [`DATA_W-1:0] merged;
  logic [`DATA_W-1:0] rd_data;
  logic [`CHK_W-1:0] rd_chk;
  logic [`DATA_W-1:0] rd_out;
  logic rd_err;
  logic slow_first;
  logic deliver;
  logic [`DATA_W-1:0] gen_data;
  logic [`CHK_W-1:0] wr_gen;
  logic [`CHK_W-1:0] wr_par;
  logic [`DATA_W-1:0] rd_fixed;
  logic rd_multi;
  logic rd_par_err;

  assign acc = req_valid_i && ready_q;
  assign ecc = (mode_q == ecc_pkg::MODE_ECC);

  // write data lanes, gather and rmw decisions
  always_comb
  begin
    wdata = req_i.data;
    wbe = req_i.be;
    gather = 1'b0;
    combine = 1'b0;
    if (req_i.pci)
    begin
      wdata = {req_i.data[`HALF_W-1:0], req_i.data[`HALF_W-1:0]};
      wbe = req_i.upper ? {req_i.be[3:0], `LANE_NONE} : {`LANE_NONE, req_i.be[3:0]};
      if (ecc && req_i.write)
      begin
        // a partial lower phase is held as well and settled by rmw later
        gather = !req_i.last && !req_i.upper;
        combine = hold_vld_q && req_i.upper && (req_i.grp == hold_grp_q);
        if (combine)
        begin
          wdata = {req_i.data[`HALF_W-1:0], hold_q};
          wbe = {req_i.be[3:0], hold_be_q};
        end
      end
    end
    need_rmw = ecc && (wbe != `BYTE_ALL);
  end

  // read path: the ecc first cpu beat is checked from the held copy
  assign rd_data = (state_q == S_RD_CHECK) ? raw_q : mem_rdata_i;
  assign rd_chk = (state_q == S_RD_CHECK) ? raw_chk_q : mem_rchk_i;
  assign rd_out = ecc ? rd_fixed : rd_data;
  assign slow_first = ecc && !cur_q.pci && cur_q.first;
  assign deliver = ((state_q == S_RD_WAIT) && mem_rvalid_i && !slow_first)
    || (state_q == S_RD_CHECK);

  always_comb
  begin
    rd_err = 1'b0;
    case (mode_q)
      ecc_pkg::MODE_PARITY: rd_err = rd_par_err;
      ecc_pkg::MODE_ECC: rd_err = rd_multi;
      default: rd_err = 1'b0;
    endcase
  end

  // corrected old data fills the bytes the requester leaves alone
  always_comb
  begin
    merged = rd_fixed;
    for (int b = 0; b < `CHK_W; b++)
    begin
      if (wbe_q[b])
      begin
        merged[8*b +: 8] = wd_q[8*b +: 8];
      end
    end
  end

  assign gen_data = (state_q == S_RMW_RD) ? merged : wdata;

  ecc_codec u_wr_codec (
    .data_i(gen_data),
    .chk_i(`CHK_RST),
    .gen_o(wr_gen),
    .par_o(wr_par),
    .fixed_o(),
    .single_o(),
    .multi_o(),
    .par_err_o()
  );

  ecc_codec u_rd_codec (
    .data_i(rd_data),
    .chk_i(rd_chk),
    .gen_o(),
    .par_o(),
    .fixed_o(rd_fixed),
    .single_o(),
    .multi_o(rd_multi),
    .par_err_o(rd_par_err)
  );

  // sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
      begin
        if (acc && !req_i.write)
        begin
          state_d = S_RD_WAIT;
        end
        else if (acc && !gather && need_rmw)
        begin
          state_d = S_RMW_RD;
        end
      end
      S_RD_WAIT:
      begin
        if (mem_rvalid_i)
        begin
          state_d = slow_first ? S_RD_CHECK : S_IDLE;
        end
      end
      S_RD_CHECK: state_d = S_IDLE;
      S_RMW_RD:
      begin
        if (mem_rvalid_i)
        begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= S_IDLE;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ready_q <= (state_d == S_IDLE);
    end
  end

  // mode changes only while nothing is open, a held half included
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_q <= ecc_pkg::MODE_NONE;
    end
    else if ((state_q == S_IDLE) && !acc && !hold_vld_q)
    begin
      mode_q <= cfg_mode_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cur_q <= '0;
      wd_q <= `DATA_RST;
      wbe_q <= `BYTE_NONE;
    end
    else if (acc)
    begin
      cur_q <= req_i;
      wd_q <= wdata;
      wbe_q <= wbe;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      raw_q <= `DATA_RST;
      raw_chk_q <= `CHK_RST;
    end
    else if ((state_q == S_RD_WAIT) && mem_rvalid_i)
    begin
      raw_q <= mem_rdata_i;
      raw_chk_q <= mem_rchk_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hold_q <= `HALF_RST;
      hold_be_q <= `LANE_NONE;
      hold_grp_q <= `GRP_RST;
      hold_vld_q <= 1'b0;
    end
    else if (acc && gather)
    begin
      hold_q <= req_i.data[`HALF_W-1:0];
      hold_be_q <= req_i.be[3:0];
      hold_grp_q <= req_i.grp;
      hold_vld_q <= 1'b1;
    end
    else if (acc && combine)
    begin
      hold_vld_q <= 1'b0;
    end
  end

  // dram requests; a corrected word only ever reaches dram merged into an rmw
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mem_q <= '0;
    end
    else
    begin
      mem_q.valid <= 1'b0;
      if (acc && !req_i.write)
      begin
        mem_q.valid <= 1'b1;
        mem_q.write <= 1'b0;
        mem_q.grp <= req_i.grp;
        mem_q.be <= `BYTE_ALL;
      end
      else if (acc && !gather && need_rmw)
      begin
        mem_q.valid <= 1'b1;
        mem_q.write <= 1'b0;
        mem_q.grp <= req_i.grp;
        mem_q.be <= `BYTE_ALL;
      end
      else if (acc && !gather)
      begin
        mem_q.valid <= 1'b1;
        mem_q.write <= 1'b1;
        mem_q.grp <= req_i.grp;
        mem_q.data <= wdata;
        mem_q.chk <= ecc ? wr_gen : wr_par;
        mem_q.be <= wbe;
      end
      else if ((state_q == S_RMW_RD) && mem_rvalid_i && !rd_multi)
      begin
        // an uncorrectable old word is not rewritten with fresh check bits
        mem_q.valid <= 1'b1;
        mem_q.write <= 1'b1;
        mem_q.data <= merged;
        mem_q.chk <= wr_gen;
        mem_q.be <= `BYTE_ALL;
      end
    end
  end

  // answers; cpu data and ack leave together, never data ahead of its check
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cpu_data_q <= `DATA_RST;
      ta_n_q <= 1'b1;
      tea_n_q <= 1'b1;
      mcp_n_q <= 1'b1;
      pci_data_q <= `DATA_RST;
      pci_vld_q <= 1'b0;
      serr_n_q <= 1'b1;
    end
    else
    begin
      ta_n_q <= 1'b1;
      tea_n_q <= 1'b1;
      mcp_n_q <= 1'b1;
      pci_vld_q <= 1'b0;
      serr_n_q <= 1'b1;
      if (deliver && cur_q.pci)
      begin
        pci_data_q <= rd_out;
        pci_vld_q <= 1'b1;
        serr_n_q <= !rd_err;
      end
      else if (deliver)
      begin
        cpu_data_q <= rd_out;
        ta_n_q <= rd_err && !cfg_err_mcp_i;
        tea_n_q <= !(rd_err && !cfg_err_mcp_i);
        mcp_n_q <= !(rd_err && cfg_err_mcp_i);
      end
      else if ((state_q == S_RMW_RD) && mem_rvalid_i && rd_multi)
      begin
        serr_n_q <= !cur_q.pci;
        tea_n_q <= !(!cur_q.pci && !cfg_err_mcp_i);
        mcp_n_q <= !(!cur_q.pci && cfg_err_mcp_i);
      end
    end
  end

  assign req_ready_o = ready_q;
  assign mem_req_o = mem_q;
  assign cpu_data_o = cpu_data_q;
  assign transfer_ack_n_o = ta_n_q;
  assign transfer_error_ack_n_o = tea_n_q;
  assign machine_check_n_o = mcp_n_q;
  assign data_retry_n_o = 1'b1;
  assign pci_data_o = pci_data_q;
  assign pci_data_valid_o = pci_vld_q;
  assign pci_serr_n_o = serr_n_q;

  retry_never_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) data_retry_n_o)
    else $error("data retry asserted");

  ecc_first_beat_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (state_q == S_RD_WAIT && mem_rvalid_i && slow_first)
    |=> (transfer_ack_n_o && transfer_error_ack_n_o) ##1
    (!transfer_ack_n_o || !transfer_error_ack_n_o || !machine_check_n_o))
    else $error("ecc first beat not exactly one clock late");

  fast_cpu_read_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (state_q == S_RD_WAIT && mem_rvalid_i && !ecc && !cur_q.pci)
    |=> (!transfer_ack_n_o || !transfer_error_ack_n_o || !machine_check_n_o))
    else $error("non-ecc cpu read delayed");

  pci_read_speed_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (state_q == S_RD_WAIT && mem_rvalid_i && cur_q.pci) |=> pci_data_valid_o)
    else $error("pci read delayed");

  full_group_read_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (mem_req_o.valid && !mem_req_o.write) |-> (mem_req_o.be == `BYTE_ALL))
    else $error("read of less than a full group");

  ecc_full_write_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (mem_req_o.valid && mem_req_o.write && ecc) |-> (mem_req_o.be == `BYTE_ALL))
    else $error("partial ecc write reached dram");

  partial_plain_write_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (acc && req_i.write && !req_i.pci && !ecc)
    |=> (mem_req_o.valid && mem_req_o.write && mem_req_o.be == $past(req_i.be)))
    else $error("non-ecc cpu write not passed straight through");

  rmw_start_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (acc && req_i.write && !req_i.pci && ecc && req_i.be != `BYTE_ALL)
    |=> (state_q == S_RMW_RD && mem_req_o.valid && !mem_req_o.write))
    else $error("short ecc write did not start rmw");

  parity_byte_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    (mem_req_o.valid && mem_req_o.write && $past(mode_q) == ecc_pkg::MODE_PARITY)
    |-> (mem_req_o.chk[0] == ~^mem_req_o.data[7:0]))
    else $error("byte parity wrong");

  serr_pulse_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) !pci_serr_n_o |=> pci_serr_n_o)
    else $error("serr longer than one clock");

endmodule

`default_nettype wire

// ===== ecc_map.svh
// constants for the memory check path: widths, masks, reset values
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH

`define GRP_W 29
`define DATA_W 64
`define CHK_W 8
`define HALF_W 32

`define BYTE_ALL 8'hFF
`define BYTE_NONE 8'h00
`define LANE_ALL 4'hF
`define LANE_NONE 4'h0
`define CHK_RST 8'h00
`define DATA_RST 64'h0000_0000_0000_0000
`define HALF_RST 32'h0000_0000
`define GRP_RST 29'h0000_0000

// data bits feeding each check bit, bit 0 least significant
`define ECC_MASK0 64'h8E8E_8E8E_0000_FFFF
`define ECC_MASK1 64'h4D4D_4D4D_FF00_FF00
`define ECC_MASK2 64'h2B2B_2B2B_FFFF_0000
`define ECC_MASK3 64'h1717_1717_00FF_00FF
`define ECC_MASK4 64'h0000_FFFF_8E8E_8E8E
`define ECC_MASK5 64'hFF00_FF00_4D4D_4D4D
`define ECC_MASK6 64'hFFFF_0000_2B2B_2B2B
`define ECC_MASK7 64'h00FF_00FF_1717_1717

`endif

// ===== ecc_pkg.sv
// types shared by the memory check path
`default_nettype none
`include "ecc_map.svh"

package ecc_pkg;

  typedef enum logic [1:0] {MODE_NONE, MODE_PARITY, MODE_ECC} mode_t;

  // one request: a processor beat (8 bytes) or a pci data phase (low 4 bytes used)
  typedef struct packed {
    logic pci;
    logic write;
    logic first;
    logic last;
    logic [`GRP_W-1:0] grp;
    logic upper;
    logic [`DATA_W-1:0] data;
    logic [`CHK_W-1:0] be;
  } req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`GRP_W-1:0] grp;
    logic [`DATA_W-1:0] data;
    logic [`CHK_W-1:0] chk;
    logic [`CHK_W-1:0] be;
  } mem_req_t;

endpackage

`default_nettype wire

// ===== ecc_codec.sv
// check-bit generation, syndrome decode, single-bit correction and byte parity
`default_nettype none
`include "ecc_map.svh"

module ecc_codec (
  // word under test
  input wire logic [`DATA_W-1:0] data_i,
  input wire logic [`CHK_W-1:0] chk_i,
  // results
  output logic [`CHK_W-1:0] gen_o,
  output logic [`CHK_W-1:0] par_o,
  output logic [`DATA_W-1:0] fixed_o,
  output logic single_o,
  output logic multi_o,
  output logic par_err_o
);

  localparam logic [`CHK_W-1:0][`DATA_W-1:0] H = {`ECC_MASK7, `ECC_MASK6, `ECC_MASK5,
    `ECC_MASK4, `ECC_MASK3, `ECC_MASK2, `ECC_MASK1, `ECC_MASK0};

  logic [`CHK_W-1:0] syn;
  logic [`CHK_W-1:0] col;
  logic hit;
  logic cb_hit;

  always_comb
  begin
    syn = `CHK_RST;
    col = `CHK_RST;
    hit = 1'b0;
    fixed_o = data_i;
    for (int i = 0; i < `CHK_W; i++)
    begin
      gen_o[i] = ^(data_i & H[i]);
      par_o[i] = ~^data_i[8*i +: 8];
    end
    syn = gen_o ^ chk_i;
    // a data bit in error leaves its own matrix column as syndrome
    for (int j = 0; j < `DATA_W; j++)
    begin
      for (int k = 0; k < `CHK_W; k++)
      begin
        col[k] = H[k][j];
      end
      if (syn == col)
      begin
        fixed_o[j] = ~data_i[j];
        hit = 1'b1;
      end
    end
    cb_hit = (syn != `CHK_RST) && ((syn & (syn - 8'h01)) == `CHK_RST);
    single_o = hit | cb_hit;
    multi_o = (syn != `CHK_RST) && !single_o;
    // an even count of flipped bits in a byte cancels out here
    par_err_o = |(par_o ^ chk_i);
  end

endmodule

`default_nettype wire

// ===== mem_model.sv
// dram stand-in for the memory check path: 16 words of 72 bits
`default_nettype none
`include "ecc_map.svh"
module mem_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // requests from the design
  input wire ecc_pkg::mem_req_t mem_req_i,
  // bench controls: answer delay and bits corrupted on the answer
  input wire logic [1:0] delay_i,
  input wire logic [71:0] flip_i,
  // read answer
  output logic [`DATA_W-1:0] rdata_o,
  output logic [`CHK_W-1:0] rchk_o,
  output logic rvalid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [71:0] cell_q [16];
  logic [2:0] wait_q;
  logic [3:0] addr_q;
  // only enabled byte lanes and their check bits are written
  always_ff @(posedge clock_i)
    if (mem_req_i.valid && mem_req_i.write)
      for (int i = 0; i < 8; i++)
        if (mem_req_i.be[i])
        begin
          cell_q[mem_req_i.grp[3:0]][8*i+:8] <= mem_req_i.data[8*i+:8];
          cell_q[mem_req_i.grp[3:0]][64+i] <= mem_req_i.chk[i];
        end
  // idle read lines toggle so stale data never passes for an answer
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      wait_q <= 3'h0;
      addr_q <= 4'h0;
      rvalid_o <= 1'b0;
      {rchk_o, rdata_o} <= 72'h0;
    end
    else
    begin
      rvalid_o <= wait_q == 3'h1;
      {rchk_o, rdata_o} <= wait_q == 3'h1 ? cell_q[addr_q] ^ flip_i : ~{rchk_o, rdata_o};
      if (mem_req_i.valid && !mem_req_i.write)
      begin
        wait_q <= {1'b0, delay_i} + 3'h1;
        addr_q <= mem_req_i.grp[3:0];
      end
      else if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the memory check path against a dram model
`default_nettype none
`include "ecc_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0] kind;
    logic [63:0] data;
    logic [7:0] be;
    logic [7:0] chk;
    logic [7:0] cmask;
    logic err;
    int lat;
  } note_t;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b1;
  ecc_pkg::mode_t mode = ecc_pkg::MODE_NONE;
  logic mcp = 1'b0;
  logic req_valid = 1'b0;
  ecc_pkg::req_t req = '0;
  logic [1:0] delay = 2'h0;
  logic [71:0] flip = '0;
  logic ready, ack_n, tea_n, mcp_n, retry_n, pci_valid, serr_n, rvalid;
  logic [63:0] cpu_data, pci_data, rdata;
  logic [7:0] rchk;
  ecc_pkg::mem_req_t mreq;
  logic [71:0] shadow [16];
  note_t q [$];
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h3a0ab529;
  int lat = 0;
  int pcode [4] = '{0, 1, 2, 4};
  time t0;

  always #4 clock_i = ~clock_i;

  memory_ecc_parity_checker memory_ecc_parity_checker_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_mode_i(mode), .cfg_err_mcp_i(mcp),
    .req_valid_i(req_valid), .req_i(req), .req_ready_o(ready), .cpu_data_o(cpu_data),
    .transfer_ack_n_o(ack_n), .transfer_error_ack_n_o(tea_n), .machine_check_n_o(mcp_n),
    .data_retry_n_o(retry_n), .pci_data_o(pci_data), .pci_data_valid_o(pci_valid),
    .pci_serr_n_o(serr_n), .mem_req_o(mreq), .mem_rdata_i(rdata), .mem_rchk_i(rchk),
    .mem_rvalid_i(rvalid)
  );
  mem_model mem_model_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .mem_req_i(mreq), .delay_i(delay),
    .flip_i(flip), .rdata_o(rdata), .rchk_o(rchk), .rvalid_o(rvalid)
  );

  function automatic logic [7:0] ecc_of(logic [63:0] d);
    logic [63:0] m [8] = '{`ECC_MASK0, `ECC_MASK1, `ECC_MASK2, `ECC_MASK3,
      `ECC_MASK4, `ECC_MASK5, `ECC_MASK6, `ECC_MASK7};
    for (int i = 0; i < 8; i++)
      ecc_of[i] = ^(d & m[i]);
  endfunction
  function automatic logic [7:0] par_of(logic [63:0] d);
    for (int i = 0; i < 8; i++)
      par_of[i] = ~^d[8*i+:8];
  endfunction
  function automatic logic [63:0] lanes(logic [7:0] be);
    for (int i = 0; i < 8; i++)
      lanes[8*i+:8] = {8{be[i]}};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic take(logic [1:0] kind, logic [63:0] d, logic [7:0] c, logic [7:0] be,
    logic err);
    note_t n;
    if (q.size() == 0)
    begin
      cmp_count++;
      fail_count++;
      $display("unexpected result: expected none, seen kind %0d", kind);
      return;
    end
    n = q.pop_front();
    check("result kind", 64'(kind), 64'(n.kind));
    check("error report", 64'(err), 64'(n.err));
    if (n.lat != 0)
      check("cycles after memory data", 64'(lat), 64'(n.lat));
    if (!n.err)
      check("data", d & lanes(n.be), n.data & lanes(n.be));
    if (kind == 2'h0)
    begin
      check("byte enables", 64'(be), 64'(n.be));
      check("check bits", 64'(c & n.cmask), 64'(n.chk & n.cmask));
    end
  endtask

  // results are taken off the queue oldest first
  always @(posedge clock_i)
  begin
    lat = rvalid ? 0 : lat + 1;
    check("data retry", 64'(retry_n), 64'h1);
    if (mreq.valid && !mreq.write)
      check("read byte enables", 64'(mreq.be), 64'hFF);
    if (mreq.valid && mreq.write)
      take(2'h0, mreq.data, mreq.chk, mreq.be, 1'b0);
    if (!ack_n || !tea_n || !mcp_n)
      take(2'h1, cpu_data, 8'h00, 8'hFF, !tea_n || !mcp_n);
    if (pci_valid || !serr_n)
      take(2'h2, pci_data, 8'h00, 8'hFF, !serr_n);
  end

  task automatic step(int n);
    repeat (n)
    begin
      @(posedge clock_i);
      #1;
    end
  endtask
  // valid stays up after the taking edge so that phases can run back to back
  task automatic send(logic pci, logic wr, logic first, logic last, logic [28:0] g,
    logic up, logic [63:0] d, logic [7:0] be);
    req = '{pci, wr, first, last, g, up, d, be};
    req_valid = 1'b1;
    while (!ready)
      step(1);
    step(1);
  endtask
  task automatic settle();
    req_valid = 1'b0;
    for (int i = 0; i < 40 && q.size() != 0; i++)
      step(1);
    if (q.size() != 0)
      check("pending results", 64'(q.size()), 64'h0);
    q.delete();
    step(1);
  endtask
  task automatic pick(int code, output logic [71:0] f);
    int b;
    b = {$random(seed)} % 64;
    f = '0;
    if (code == 1 || code == 3 || code == 4)
      f[b] = 1'b1;
    if (code == 2 || code == 3)
      f[64 + (b + 3) % 8] = 1'b1;
    if (code == 4)
      f[b ^ 1] = 1'b1;
  endtask
  task automatic expect_write(logic [3:0] g, logic [63:0] d, logic [7:0] be);
    logic ecc;
    logic [63:0] m;
    logic [7:0] c;
    logic [7:0] cm;
    ecc = mode == ecc_pkg::MODE_ECC;
    m = (shadow[g][63:0] & ~lanes(be)) | (d & lanes(be));
    c = ecc ? ecc_of(m) : par_of(m);
    cm = ecc ? 8'hFF : (mode == ecc_pkg::MODE_PARITY ? be : 8'h00);
    q.push_back('{2'h0, m, ecc ? 8'hFF : be, c, cm, 1'b0, (ecc && be != 8'hFF) ? 1 : 0});
    shadow[g] = {(shadow[g][71:64] & ~cm) | (c & cm), m};
  endtask
  task automatic wr(logic [3:0] g, logic [7:0] be, int code);
    logic [63:0] d;
    d = {$random(seed), $random(seed)};
    pick(code, flip);
    delay = 2'($random(seed));
    // an uncorrectable old word leaves memory alone and reports an error instead
    if (code == 3)
      q.push_back('{2'h1, 64'h0, 8'hFF, 8'h00, 8'h00, 1'b1, 1});
    else
      expect_write(g, d, be);
    send(1'b0, 1'b1, 1'b1, 1'b0, {25'h0, g}, 1'b0, d, be);
  endtask
  task automatic pair(logic [3:0] g, logic [3:0] be_lo);
    logic [63:0] d;
    d = {$random(seed), $random(seed)};
    pick(0, flip);
    // without ecc each phase is its own write on its own lanes
    if (mode == ecc_pkg::MODE_ECC)
      expect_write(g, d, {4'hF, be_lo});
    else
    begin
      expect_write(g, {2{d[31:0]}}, {4'h0, be_lo});
      expect_write(g, {2{d[63:32]}}, 8'hF0);
    end
    send(1'b1, 1'b1, 1'b0, 1'b0, {25'h0, g}, 1'b0, {32'h0, d[31:0]}, {4'h0, be_lo});
    send(1'b1, 1'b1, 1'b0, 1'b1, {25'h0, g}, 1'b1, {32'h0, d[63:32]}, 8'h0F);
    settle();
  endtask
  // the bench uses read data on the acknowledge edge, never waiting for a retry
  task automatic rd(logic pci, logic first, logic [3:0] g, int code);
    logic [71:0] raw;
    logic err;
    logic ecc;
    pick(code, flip);
    ecc = mode == ecc_pkg::MODE_ECC;
    raw = shadow[g] ^ flip;
    err = ecc ? $countones(flip) > 1 :
      mode == ecc_pkg::MODE_PARITY && |(par_of(raw[63:0]) ^ raw[71:64]);
    q.push_back('{pci ? 2'h2 : 2'h1, ecc ? shadow[g][63:0] : raw[63:0], 8'hFF, 8'h00,
      8'h00, err, (ecc && !pci && first) ? 2 : 1});
    mcp = 1'($random(seed));
    delay = 2'($random(seed));
    send(pci, 1'b0, first, 1'b1, {25'h0, g}, 1'b0, 64'h0, 8'hFF);
    settle();
  endtask

  initial
  begin
    #1;
    rst_b_i = 1'b0;
    step(12);
    rst_b_i = 1'b1;
    mode = ecc_pkg::MODE_ECC;
    step(3);
    t0 = $time;
    for (int g = 0; g < 4; g++)
      wr(4'(g), 8'hFF, 0);
    check("cycles for four full writes", 64'(($time - t0) / 8), 64'h4);
    settle();
    for (int k = 0; k < 16; k++)
      rd(k[3], k[2], 4'(k % 4), k % 4);
    wr(4'h1, 8'h0F, 1);
    settle();
    wr(4'h1, 8'hF0, 3);
    settle();
    rd(1'b0, 1'b1, 4'h1, 0);
    pair(4'h2, 4'hF);
    pair(4'h3, 4'h3);
    rd(1'b1, 1'b0, 4'h2, 0);
    rd(1'b1, 1'b0, 4'h3, 0);
    mode = ecc_pkg::MODE_PARITY;
    step(2);
    for (int g = 4; g < 8; g++)
      wr(4'(g), 8'hFF, 0);
    wr(4'h4, 8'h30, 0);
    settle();
    pair(4'h6, 4'h5);
    for (int k = 0; k < 8; k++)
      rd(k[0], 1'b1, 4'(4 + k / 2), pcode[k / 2]);
    mode = ecc_pkg::MODE_NONE;
    step(2);
    wr(4'h5, 8'h01, 0);
    settle();
    rd(1'b0, 1'b1, 4'h5, 1);
    rd(1'b1, 1'b0, 4'h5, 3);
    report_and_stop();
  end

  // the whole sequence needs a few hundred cycles at most
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
